// ---- verilog/srst_ctrl.sv ----
// Peripheral soft reset control: two masked reset registers
`default_nettype none

module srst_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [31:0] capability_mask_a,
  input  wire logic [31:0] capability_mask_b,
  output logic             pulse_width_reset,
  output logic             converter_zero_reset,
  output logic             watchdog_reset,
  output logic             comparator_one_reset,
  output logic             comparator_zero_reset,
  output logic             gp_counter_two_reset,
  output logic             gp_counter_one_reset,
  output logic             gp_counter_zero_reset,
  output logic             two_wire_zero_reset,
  output logic             sync_serial_zero_reset,
  output logic             async_serial_one_reset,
  output logic             async_serial_zero_reset
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  srst_acc_if acc ();

  logic [31:0] ctrl_a_r;
  logic [31:0] ctrl_a_nxt;
  logic [31:0] ctrl_b_r;
  logic [31:0] ctrl_b_nxt;
  logic [31:0] drop_a_r;
  logic [31:0] drop_a_nxt;
  logic [31:0] drop_b_r;
  logic [31:0] drop_b_nxt;
  logic [31:0] rdata_nxt;
  logic [31:0] req_a;
  logic [31:0] req_b;
  logic [31:0] keep_a;
  logic [31:0] keep_b;
  logic [31:0] refuse_a;
  logic [31:0] refuse_b;
  logic        wr_a;
  logic        wr_b;
  logic        wr_da;
  logic        wr_db;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  srst_dec u_dec (
    .addr  (reg_addr),
    .wdata (reg_wdata),
    .wr    (reg_wr),
    .rd    (reg_rd),
    .acc   (acc.dec)
  );

  // ---------------------------------------------------------------
  // Write qualifiers
  // ---------------------------------------------------------------
  // One strobe per register; never more than one active
  assign wr_a  = acc.wr && acc.sel_a;
  assign wr_b  = acc.wr && acc.sel_b;
  assign wr_da = acc.wr && acc.sel_da;
  assign wr_db = acc.wr && acc.sel_db;

  // ---------------------------------------------------------------
  // Write masks
  // ---------------------------------------------------------------
  // Bits that a write to register a may actually take
  always_comb begin
    keep_a = capability_mask_a & srst_pkg::IMPL_A;
  end

  // Bits that a write to register b may actually take
  always_comb begin
    keep_b = capability_mask_b & srst_pkg::IMPL_B;
  end

  // Ones written to implemented bits whose peripheral is absent
  always_comb begin
    refuse_a = reg_wdata & srst_pkg::IMPL_A & ~capability_mask_a;
    refuse_b = reg_wdata & srst_pkg::IMPL_B & ~capability_mask_b;
  end

  // ---------------------------------------------------------------
  // Control register a next value
  // ---------------------------------------------------------------
  // Whole word replaced; absent and reserved bits land as zero
  always_comb begin
    ctrl_a_nxt = ctrl_a_r;
    if (wr_a) begin
      ctrl_a_nxt = acc.wdata & keep_a;
    end
  end

  // ---------------------------------------------------------------
  // Control register b next value
  // ---------------------------------------------------------------
  // Whole word replaced; absent and reserved bits land as zero
  always_comb begin
    ctrl_b_nxt = ctrl_b_r;
    if (wr_b) begin
      ctrl_b_nxt = acc.wdata & keep_b;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Register a: pulse-width, converter zero, watchdog
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_a_r <= srst_pkg::CTRL_RST;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
    end
  end

  // Register b: comparators, counters, serial units
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_b_r <= srst_pkg::CTRL_RST;
    end else begin
      ctrl_b_r <= ctrl_b_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Refused-bit status
  // ---------------------------------------------------------------
  // Sticky record of ones dropped by the capability mask.
  // Write one to clear; a refusal in the same cycle wins.
  always_comb begin
    drop_a_nxt = drop_a_r;
    if (wr_da) begin
      drop_a_nxt = drop_a_nxt & ~acc.wdata;
    end
    if (wr_a) begin
      drop_a_nxt = drop_a_nxt | refuse_a;
    end
  end

  // Same for register b
  always_comb begin
    drop_b_nxt = drop_b_r;
    if (wr_db) begin
      drop_b_nxt = drop_b_nxt & ~acc.wdata;
    end
    if (wr_b) begin
      drop_b_nxt = drop_b_nxt | refuse_b;
    end
  end

  // Refused-bit register a
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drop_a_r <= srst_pkg::DROP_RST;
    end else begin
      drop_a_r <= drop_a_nxt;
    end
  end

  // Refused-bit register b
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drop_b_r <= srst_pkg::DROP_RST;
    end else begin
      drop_b_r <= drop_b_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Select the addressed word; unmapped reads return zero
  always_comb begin
    rdata_nxt = srst_pkg::RDATA_RST;
    if (acc.rd && !acc.miss) begin
      case (1'b1)
        acc.sel_a: begin
          rdata_nxt = ctrl_a_r & srst_pkg::IMPL_A;
        end
        acc.sel_b: begin
          rdata_nxt = ctrl_b_r & srst_pkg::IMPL_B;
        end
        acc.sel_da: begin
          rdata_nxt = drop_a_r;
        end
        acc.sel_db: begin
          rdata_nxt = drop_b_r;
        end
        default: begin
          rdata_nxt = srst_pkg::RDATA_RST;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= srst_pkg::RDATA_RST;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Reset request flops
  // ---------------------------------------------------------------
  srst_req_drv u_drv (
    .clk    (clk),
    .rst_b  (rst_b),
    .ctrl_a (ctrl_a_r),
    .ctrl_b (ctrl_b_r),
    .req_a  (req_a),
    .req_b  (req_b)
  );

  // ---------------------------------------------------------------
  // Peripheral reset outputs, register a
  // ---------------------------------------------------------------
  assign pulse_width_reset    = req_a[srst_pkg::BIT_PULSE_WIDTH];
  assign converter_zero_reset = req_a[srst_pkg::BIT_CONV_ZERO];
  assign watchdog_reset       = req_a[srst_pkg::BIT_WATCHDOG];

  // ---------------------------------------------------------------
  // Peripheral reset outputs, register b
  // ---------------------------------------------------------------
  // Analog comparators
  assign comparator_one_reset  = req_b[srst_pkg::BIT_CMP_ONE];
  assign comparator_zero_reset = req_b[srst_pkg::BIT_CMP_ZERO];

  // General-purpose counters
  assign gp_counter_two_reset  = req_b[srst_pkg::BIT_GPC_TWO];
  assign gp_counter_one_reset  = req_b[srst_pkg::BIT_GPC_ONE];
  assign gp_counter_zero_reset = req_b[srst_pkg::BIT_GPC_ZERO];

  // Two-wire and synchronous serial units
  assign two_wire_zero_reset    = req_b[srst_pkg::BIT_TWO_WIRE];
  assign sync_serial_zero_reset = req_b[srst_pkg::BIT_SYNC_SER];

  // Asynchronous serial units
  assign async_serial_one_reset  = req_b[srst_pkg::BIT_ASYNC_ONE];
  assign async_serial_zero_reset = req_b[srst_pkg::BIT_ASYNC_ZERO];

endmodule

`default_nettype wire

// ---- verilog/srst_pkg.sv ----
// Constants shared by the peripheral soft reset control block
`default_nettype none

package srst_pkg;

  // ---------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL_A = 12'h040; // soft_reset_ctrl_a
  localparam logic [11:0] OFF_CTRL_B = 12'h044; // soft_reset_ctrl_b
  localparam logic [11:0] OFF_DROP_A = 12'h050; // refused bits, W1C
  localparam logic [11:0] OFF_DROP_B = 12'h054; // refused bits, W1C

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DROP_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Field positions, control register a
  // ---------------------------------------------------------------
  localparam int BIT_PULSE_WIDTH = 20;
  localparam int BIT_CONV_ZERO   = 16;
  localparam int BIT_WATCHDOG    = 3;

  // ---------------------------------------------------------------
  // Field positions, control register b
  // ---------------------------------------------------------------
  localparam int BIT_CMP_ONE     = 25;
  localparam int BIT_CMP_ZERO    = 24;
  localparam int BIT_GPC_TWO     = 18;
  localparam int BIT_GPC_ONE     = 17;
  localparam int BIT_GPC_ZERO    = 16;
  localparam int BIT_TWO_WIRE    = 12;
  localparam int BIT_SYNC_SER    = 4;
  localparam int BIT_ASYNC_ONE   = 1;
  localparam int BIT_ASYNC_ZERO  = 0;

  // ---------------------------------------------------------------
  // Implemented bits; all others read zero
  // ---------------------------------------------------------------
  localparam logic [31:0] IMPL_A = 32'h0011_0008;
  localparam logic [31:0] IMPL_B = 32'h0307_1013;

endpackage

`default_nettype wire

// ---- verilog/srst_acc_if.sv ----
// Decoded register access carried from decoder to core
`default_nettype none

interface srst_acc_if;
  logic        wr;       // Write strobe
  logic        rd;       // Read strobe
  logic        sel_a;    // Control register a addressed
  logic        sel_b;    // Control register b addressed
  logic        sel_da;   // Refused-bit register a addressed
  logic        sel_db;   // Refused-bit register b addressed
  logic        miss;     // No register at this address
  logic [31:0] wdata;    // Write data

  modport dec  (output wr, rd, sel_a, sel_b, sel_da, sel_db, miss, wdata);
  modport core (input  wr, rd, sel_a, sel_b, sel_da, sel_db, miss, wdata);
endinterface

`default_nettype wire

// ---- verilog/srst_dec.sv ----
// Address decoder for the soft reset register port
`default_nettype none

module srst_dec (
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  srst_acc_if.dec          acc
);

  // ---------------------------------------------------------------
  // Offset compare
  // ---------------------------------------------------------------
  always_comb begin
    acc.sel_a  = (addr == srst_pkg::OFF_CTRL_A);
    acc.sel_b  = (addr == srst_pkg::OFF_CTRL_B);
    acc.sel_da = (addr == srst_pkg::OFF_DROP_A);
    acc.sel_db = (addr == srst_pkg::OFF_DROP_B);
    acc.miss   = !(acc.sel_a || acc.sel_b || acc.sel_da || acc.sel_db);
  end

  // Strobes and data pass through unchanged
  assign acc.wr    = wr;
  assign acc.rd    = rd;
  assign acc.wdata = wdata;

endmodule

`default_nettype wire

// ---- verilog/srst_req_drv.sv ----
// Registered reset request drivers, one flop per implemented bit
`default_nettype none

module srst_req_drv (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] ctrl_a,
  input  wire logic [31:0] ctrl_b,
  output logic      [31:0] req_a,
  output logic      [31:0] req_b
);

  // ---------------------------------------------------------------
  // Per-bit request flops
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 32; i++) begin : g_bit
    if (srst_pkg::IMPL_A[i]) begin : g_a
      // Held while the control bit is one
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          req_a[i] <= 1'b0;
        end else begin
          req_a[i] <= ctrl_a[i];
        end
      end
    end else begin : g_a0
      assign req_a[i] = 1'b0;
    end
    if (srst_pkg::IMPL_B[i]) begin : g_b
      // Held while the control bit is one
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          req_b[i] <= 1'b0;
        end else begin
          req_b[i] <= ctrl_b[i];
        end
      end
    end else begin : g_b0
      assign req_b[i] = 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/srst_ctrl_properties.sv ----
// Port-level checks for the soft reset control block
`default_nettype none

module srst_ctrl_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] capability_mask_a,
  input wire logic [31:0] capability_mask_b,
  input wire logic        pulse_width_reset,
  input wire logic        converter_zero_reset,
  input wire logic        watchdog_reset,
  input wire logic        comparator_one_reset,
  input wire logic        comparator_zero_reset,
  input wire logic        gp_counter_two_reset,
  input wire logic        gp_counter_one_reset,
  input wire logic        gp_counter_zero_reset,
  input wire logic        two_wire_zero_reset,
  input wire logic        sync_serial_zero_reset,
  input wire logic        async_serial_one_reset,
  input wire logic        async_serial_zero_reset
);
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------------------------------
  // Decoded writes and masked data
  // -------------------------------------------------------------
  wire logic        wa = reg_wr && reg_addr == 12'h040;
  wire logic        wb = reg_wr && reg_addr == 12'h044;
  wire logic [31:0] ma = reg_wdata & capability_mask_a;
  wire logic [31:0] mb = reg_wdata & capability_mask_b;
  wire logic [2:0]  oa = {pulse_width_reset, converter_zero_reset, watchdog_reset};
  wire logic [8:0]  ob = {comparator_one_reset, comparator_zero_reset, gp_counter_two_reset,
                          gp_counter_one_reset, gp_counter_zero_reset, two_wire_zero_reset,
                          sync_serial_zero_reset, async_serial_one_reset, async_serial_zero_reset};

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // -------------------------------------------------------------
  // Request outputs follow masked writes two edges later
  // -------------------------------------------------------------
  pwm_req_a:
    assert property (wa |-> ##2 oa[2] == $past(ma[20], 2)) else $error("pwm request wrong");
  conv_req_a:
    assert property (wa |-> ##2 oa[1] == $past(ma[16], 2)) else $error("converter request wrong");
  wdog_req_a:
    assert property (wa |-> ##2 oa[0] == $past(ma[3], 2)) else $error("watchdog request wrong");
  cmp_req_a:
    assert property (wb |-> ##2 ob[8:7] == $past(mb[25:24], 2)) else $error("comparator request wrong");
  gpc_req_a:
    assert property (wb |-> ##2 ob[6:4] == $past(mb[18:16], 2)) else $error("counter request wrong");
  twi_req_a:
    assert property (wb |-> ##2 ob[3] == $past(mb[12], 2)) else $error("two-wire request wrong");
  ssi_req_a:
    assert property (wb |-> ##2 ob[2] == $past(mb[4], 2)) else $error("sync serial request wrong");
  uart_req_a:
    assert property (wb |-> ##2 ob[1:0] == $past(mb[1:0], 2)) else $error("async serial request wrong");
  hold_a_a:
    assert property (!wa |-> ##2 $stable(oa)) else $error("register a requests moved");
  hold_b_a:
    assert property (!wb |-> ##2 $stable(ob)) else $error("register b requests moved");
  rsv_zero_a:
    assert property (reg_rd && reg_addr == 12'h044 |=> (reg_rdata & 32'hfcf8_efec) == 32'h0)
      else $error("reserved bits read nonzero");
  rsv_first_a:
    assert property (reg_rd && reg_addr == 12'h040 |=> (reg_rdata & 32'hffee_fff7) == 32'h0)
      else $error("reserved bits of register a read nonzero");
  rst_clear_a:
    assert property (!$past(rst_b) |-> oa == 3'h0 && ob == 9'h000 && reg_rdata == 32'h0)
      else $error("outputs not clear after reset");
endmodule

bind srst_ctrl srst_ctrl_props i_srst_ctrl_props (
  .clk                     (clk),
  .rst_b                   (rst_b),
  .reg_addr                (reg_addr),
  .reg_wdata               (reg_wdata),
  .reg_wr                  (reg_wr),
  .reg_rd                  (reg_rd),
  .reg_rdata               (reg_rdata),
  .capability_mask_a       (capability_mask_a),
  .capability_mask_b       (capability_mask_b),
  .pulse_width_reset       (pulse_width_reset),
  .converter_zero_reset    (converter_zero_reset),
  .watchdog_reset          (watchdog_reset),
  .comparator_one_reset    (comparator_one_reset),
  .comparator_zero_reset   (comparator_zero_reset),
  .gp_counter_two_reset    (gp_counter_two_reset),
  .gp_counter_one_reset    (gp_counter_one_reset),
  .gp_counter_zero_reset   (gp_counter_zero_reset),
  .two_wire_zero_reset     (two_wire_zero_reset),
  .sync_serial_zero_reset  (sync_serial_zero_reset),
  .async_serial_one_reset  (async_serial_one_reset),
  .async_serial_zero_reset (async_serial_zero_reset)
);

`default_nettype wire

// ---- testbench/peripheral_soft_reset_control_bench.sv ----
// Self-checking bench for the peripheral soft reset control block
`default_nettype none

module peripheral_soft_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk          = 1'b0;
  logic        rst_b        = 1'b0;
  logic [11:0] reg_addr     = 12'h000;
  logic [31:0] reg_wdata    = 32'h0;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [31:0] mask_a       = 32'hffff_ffff;
  logic [31:0] mask_b       = 32'hffff_ffff;
  wire logic [31:0] reg_rdata;
  wire logic [2:0]  out_a;
  wire logic [8:0]  out_b;
  int          fails        = 0;
  int          total_checks = 0;

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  srst_ctrl i_srst_ctrl (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capability_mask_a(mask_a), .capability_mask_b(mask_b),
    .pulse_width_reset(out_a[2]), .converter_zero_reset(out_a[1]), .watchdog_reset(out_a[0]),
    .comparator_one_reset(out_b[8]), .comparator_zero_reset(out_b[7]),
    .gp_counter_two_reset(out_b[6]), .gp_counter_one_reset(out_b[5]),
    .gp_counter_zero_reset(out_b[4]), .two_wire_zero_reset(out_b[3]),
    .sync_serial_zero_reset(out_b[2]), .async_serial_one_reset(out_b[1]),
    .async_serial_zero_reset(out_b[0])
  );

  // ---------------------------------------------------------------
  // Bus and comparison helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp, "read data");
  endtask

  // Expected request levels from register images
  task automatic outs(input logic [31:0] va, input logic [31:0] vb);
    @(posedge clk);
    #1;
    chk({29'h0, out_a}, {29'h0, va[20], va[16], va[3]}, "requests a");
    chk({23'h0, out_b}, {23'h0, vb[25:24], vb[18:16], vb[12], vb[4], vb[1:0]}, "requests b");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(12'h040, 32'h0);
    rd(12'h044, 32'h0);
    outs(32'h0, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_reg_a;
    int ba[3] = '{20, 16, 3};
    foreach (ba[i]) begin
      wr(12'h040, 32'h1 << ba[i]);
      outs(32'h1 << ba[i], 32'h0);
    end
    wr(12'h040, 32'hffff_ffff);
    rd(12'h040, 32'h0011_0008);
    wr(12'h040, 32'h0);
    outs(32'h0, 32'h0);
    $display("register a bits done");
  endtask

  task automatic t_reg_b;
    int bb[9] = '{25, 24, 18, 17, 16, 12, 4, 1, 0};
    foreach (bb[i]) begin
      wr(12'h044, 32'h1 << bb[i]);
      outs(32'h0, 32'h1 << bb[i]);
    end
    wr(12'h044, 32'hffff_ffff);
    rd(12'h044, 32'h0307_1013);
    $display("register b bits done");
  endtask

  task automatic t_mask;
    @(posedge clk);
    mask_a <= 32'h0000_0008;
    mask_b <= 32'h0100_0001;
    wr(12'h040, 32'hffff_ffff);
    wr(12'h044, 32'hffff_ffff);
    rd(12'h040, 32'h0000_0008);
    rd(12'h044, 32'h0100_0001);
    outs(32'h0000_0008, 32'h0100_0001);
    rd(12'h050, 32'h0011_0000);
    wr(12'h050, 32'hffff_ffff);
    rd(12'h050, 32'h0);
    rd(12'h054, 32'h0207_1012);
    wr(12'h054, 32'h0000_0002);
    rd(12'h054, 32'h0207_1010);
    $display("capability masking done");
  endtask

  task automatic t_unmapped;
    wr(12'h048, 32'hffff_ffff);
    rd(12'h048, 32'h0);
    rd(12'h044, 32'h0100_0001);
    $display("unmapped access done");
  endtask

  task automatic t_midreset;
    @(posedge clk);
    mask_a <= 32'hffff_ffff;
    wr(12'h040, 32'hffff_ffff);
    outs(32'hffff_ffff, 32'h0100_0001);
    @(posedge clk);
    rst_b <= 1'b0;
    #1;
    chk({29'h0, out_a}, 32'h0, "async clear a");
    chk({23'h0, out_b}, 32'h0, "async clear b");
    outs(32'h0, 32'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h040, 32'h0);
    rd(12'h044, 32'h0);
    $display("mid-run reset done");
  endtask

  // ---------------------------------------------------------------
  // Verdict
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_reg_a();
    t_reg_b();
    t_mask();
    t_unmapped();
    t_midreset();
    end_of_test();
  end
endmodule

`default_nettype wire
